//--- rtl/pcwr_regs.sv
// configuration, pushbutton and watchdog registers of a four-port
// power-sourcing controller; times are in 10 us ticks
// assumes the serial front end presents one-cycle read/write strobes on
// core_clk_in and the port engines report status on the same clock
`timescale 1ns/1ps
module pcwr_regs
  import pcwr_pkg::*;
#(
  parameter int         WD_STEP_TICKS_P = WD_STEP_TICKS,
  parameter int         CADENCE_TICKS_P = CADENCE_TICKS,
  parameter logic [4:0] DEVICE_IDENTITY_CODE_P       = 5'h0a,  // arbitrary value
  parameter logic [2:0] REV_CODE_P      = 3'h1    // arbitrary value
)(
  input  wire logic               core_clk_in,
  input  wire logic               rst_in,
  input  wire logic               auto_pin_in,
  input  wire logic               midspan_pin_in,
  input  wire pcwr_req_type       reg_req_in,
  input  wire pcwr_port_stat_type port_stat_in,
  input  wire logic [3:0]         fault_prog_in,
  input  wire logic [3:0]         start_prog_in,
  output logic [7:0]              reg_rdata_out,
  output pcwr_cfg_type            cfg_out,
  output pcwr_ctrl_type           ctrl_out,
  output logic                    takeover_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic hit(input pcwr_req_type r, input logic [7:0] a,
                               input logic rd);
    hit = (rd ? r.read : r.write) && (r.addr == a);
  endfunction

  // nominal startup or fault time from a four-bit value
  function automatic logic [TW-1:0] nominal(input logic [3:0] p);
    nominal = TNOM_BASE_TICKS + TW'(TNOM_STEP_TICKS * TW'(p));
  endfunction

  // startup and fault share one scaling table
  function automatic logic [TW-1:0] scale_sf(input logic [TW-1:0] t,
                                             input logic [1:0] c);
    unique case (c)
      2'b00: scale_sf = t;
      2'b01: scale_sf = t >> 1;
      2'b10: scale_sf = t << 1;
      2'b11: scale_sf = t << 2;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic               auto_s1, auto_s2, mid_s1, mid_s2;
  logic               chip_rst_reg;
  logic               rst_all;
  logic [7:0]         mode_reg, disc_reg, detcls_reg, timing_reg, misc_reg;
  logic [3:0]         bckoff_reg, flags_reg, flags_next;
  logic [7:0]         pwr_pb_reg, glob_pb_reg, wd_cnt_reg, swmode_reg;
  pcwr_ctl_state_type ctl_state_reg;
  logic [7:0]         tick_cnt_reg;
  logic               tick_reg;
  logic [23:0]        wd_sub_reg;
  logic               wd_en, wd_step, expire, hw_mode;
  logic [TW-1:0]      restart_cnt_reg [4];
  logic [TW-1:0]      cadence_cnt_reg [4];
  logic [TW-1:0]      fault_t, restart_t;
  logic [3:0]         on_ok, off_ok, denied, block;
  logic [7:0]         rd_value;

  ////////////////////////////////////////////////////////////////////////////
  // strap synchronisers; straps are taken during reset as reset values

  always_ff @(posedge core_clk_in)
  begin
    auto_s1 <= auto_pin_in;
    auto_s2 <= auto_s1;
    mid_s1  <= midspan_pin_in;
    mid_s2  <= mid_s1;
  end

  // chip reset button drives a one-cycle internal reset
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      chip_rst_reg <= 1'b0;
    else
      chip_rst_reg <= hit(reg_req_in, ADDR_GLOBPB, 1'b0)
                      && reg_req_in.wdata[GPB_CHIP_BIT];
  end

  assign rst_all = rst_in | chip_rst_reg;
  assign wd_en   = swmode_reg[SW_EN_BIT];
  assign hw_mode = (ctl_state_reg == CTL_HW);
  assign expire  = wd_en && (wd_cnt_reg == WDCNT_RST) && !hw_mode;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
    begin
      mode_reg   <= {8{auto_s2}};
      disc_reg   <= {4'h0, {4{auto_s2}}};
      detcls_reg <= {8{auto_s2}};
      bckoff_reg <= {4{auto_s2 & mid_s2}};
      timing_reg <= TIMING_RST;
      misc_reg   <= MISC_RST;
      swmode_reg <= SWMODE_RST;
    end
    else
    begin
      if (expire)
      begin
        for (int i = 0; i < 4; i++)
          mode_reg[2*i +: 2] <= swmode_reg[i] ? MODE_AUTO : MODE_SHUT;
      end
      else if (hit(reg_req_in, ADDR_MODE, 1'b0) && !hw_mode)
        mode_reg <= reg_req_in.wdata;
      if (hit(reg_req_in, ADDR_DISC, 1'b0))
        disc_reg <= reg_req_in.wdata;
      if (hit(reg_req_in, ADDR_DETCLS, 1'b0))
        detcls_reg <= reg_req_in.wdata;
      if (hit(reg_req_in, ADDR_BCKOFF, 1'b0))
        bckoff_reg <= reg_req_in.wdata[3:0];
      if (hit(reg_req_in, ADDR_TIMING, 1'b0))
        timing_reg <= reg_req_in.wdata;
      if (hit(reg_req_in, ADDR_MISC, 1'b0))
        misc_reg <= reg_req_in.wdata & MISC_WMASK;
      if (hit(reg_req_in, ADDR_SWMODE, 1'b0))
        swmode_reg <= reg_req_in.wdata & SWMODE_WMSK;
    end
  end

  // pushbuttons live one cycle: written, executed, gone
  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
    begin
      pwr_pb_reg  <= 8'h00;
      glob_pb_reg <= 8'h00;
    end
    else
    begin
      pwr_pb_reg  <= hit(reg_req_in, ADDR_PWRPB, 1'b0)
                     ? reg_req_in.wdata : 8'h00;
      glob_pb_reg <= hit(reg_req_in, ADDR_GLOBPB, 1'b0)
                     ? reg_req_in.wdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 10 us tick and watchdog

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all || tick_cnt_reg == 8'(TICK_CYCLES - 1))
      tick_cnt_reg <= 8'h00;
    else
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
      tick_reg <= 1'b0;
    else
      tick_reg <= (tick_cnt_reg == 8'(TICK_CYCLES - 1));
  end

  // prescaler runs only while enabled, so a fresh enable gets a full step
  always_ff @(posedge core_clk_in)
  begin
    if (rst_all || !wd_en || wd_step)
      wd_sub_reg <= 24'h00_0000;
    else if (tick_reg)
      wd_sub_reg <= wd_sub_reg + 24'h00_0001;
  end

  assign wd_step = tick_reg && (wd_sub_reg == 24'(WD_STEP_TICKS_P - 1));

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
      wd_cnt_reg <= WDCNT_RST;
    else if (hit(reg_req_in, ADDR_WDCNT, 1'b0))
      wd_cnt_reg <= reg_req_in.wdata;
    else if (wd_en && wd_step && wd_cnt_reg != 8'h00)
      wd_cnt_reg <= wd_cnt_reg - 8'h01;
  end

  // hardware control stays until the watchdog is disabled
  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
      ctl_state_reg <= CTL_SW;
    else
    begin
      unique case (ctl_state_reg)
        CTL_SW: if (expire) ctl_state_reg <= CTL_HW;
        CTL_HW: if (!wd_en) ctl_state_reg <= CTL_SW;
        default: ctl_state_reg <= CTL_SW;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // restart and cadence timers

  assign fault_t   = scale_sf(nominal(fault_prog_in),
                              timing_reg[TM_FAULT_LSB +: 2]);
  always_comb
  begin
    unique case (timing_reg[TM_RSTR_LSB +: 2])
      2'b00: restart_t = fault_t << 4;
      2'b01: restart_t = fault_t << 5;
      2'b10: restart_t = fault_t << 6;
      2'b11: restart_t = '0;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (rst_all)
        restart_cnt_reg[i] <= '0;
      else if (port_stat_in.oc_shutdown[i])
        restart_cnt_reg[i] <= restart_t;
      else if (tick_reg && restart_cnt_reg[i] != '0)
        restart_cnt_reg[i] <= restart_cnt_reg[i] - TW'(1);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (rst_all)
        cadence_cnt_reg[i] <= '0;
      else if (port_stat_in.detect_fail[i] && bckoff_reg[i])
        cadence_cnt_reg[i] <= TW'(CADENCE_TICKS_P);
      else if (tick_reg && cadence_cnt_reg[i] != '0)
        cadence_cnt_reg[i] <= cadence_cnt_reg[i] - TW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pushbutton qualification

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      block[i]  = (misc_reg[MISC_RESTART_BIT] && restart_cnt_reg[i] != '0)
                  || (misc_reg[MISC_CLFAIL_BIT] && port_stat_in.class_fail[i]
                      && mode_reg[2*i +: 2] == MODE_AUTO);
      denied[i] = pwr_pb_reg[i] && hw_mode;
      on_ok[i]  = pwr_pb_reg[i] && !hw_mode && !block[i]
                  && !port_stat_in.powered[i]
                  && mode_reg[2*i +: 2] != MODE_SHUT
                  && mode_reg[2*i +: 2] != MODE_AUTO;
      off_ok[i] = pwr_pb_reg[4+i] && port_stat_in.powered[i]
                  && mode_reg[2*i +: 2] != MODE_SHUT;
    end
  end

  // commands and config toward the port engines
  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
    begin
      ctrl_out <= '0;
      cfg_out  <= '0;
    end
    else
    begin
      ctrl_out.power_on         <= on_ok;
      ctrl_out.abort_discovery  <= on_ok & port_stat_in.detecting;
      ctrl_out.power_off        <= off_ok | glob_pb_reg[3:0];
      ctrl_out.soft_reset       <= glob_pb_reg[3:0];
      ctrl_out.clear_all_events <= glob_pb_reg[GPB_CLR_BIT];
      ctrl_out.power_block      <= block;
      for (int i = 0; i < 4; i++)
        ctrl_out.cadence_hold[i] <= (cadence_cnt_reg[i] != '0);
      cfg_out.ac_disconnect_enable <= disc_reg[7:4];
      cfg_out.dc_disconnect_enable <= disc_reg[3:0];
      cfg_out.det_enable           <= detcls_reg[3:0];
      cfg_out.class_enable         <= detcls_reg[7:4];
      cfg_out.class_only   <= detcls_reg[7:4] & ~detcls_reg[3:0];
      cfg_out.cadence_enable       <= bckoff_reg;
      cfg_out.class_based_limit    <= misc_reg[MISC_CLLIM_BIT];
      cfg_out.fault_time           <= fault_t;
      cfg_out.start_time   <= scale_sf(nominal(start_prog_in),
                                       timing_reg[TM_START_LSB +: 2]);
      cfg_out.restart_time         <= restart_t;
      unique case (timing_reg[TM_DISC_LSB +: 2])
        2'b00: cfg_out.disc_time <= DISC_NOM_TICKS;
        2'b01: cfg_out.disc_time <= DISC_NOM_TICKS >> 2;
        2'b10: cfg_out.disc_time <= DISC_NOM_TICKS >> 1;
        2'b11: cfg_out.disc_time <= DISC_NOM_TICKS << 1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // takeover flags, interrupt and read port

  // a set in the cycle of the clearing read survives it
  assign flags_next = (hit(reg_req_in, ADDR_FLAGS, 1'b1) ? FLAGS_RST
                       : flags_reg) | (expire ? 4'hf : 4'h0) | denied;

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
      flags_reg <= FLAGS_RST;
    else
      flags_reg <= flags_next;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
      takeover_irq_out <= 1'b0;
    else
      takeover_irq_out <= swmode_reg[SW_INT_BIT] && (|flags_reg);
  end

  // button registers read as zero
  always_comb
  begin
    unique case (reg_req_in.addr)
      ADDR_MODE:   rd_value = mode_reg;
      ADDR_DISC:   rd_value = disc_reg;
      ADDR_DETCLS: rd_value = detcls_reg;
      ADDR_BCKOFF: rd_value = {4'h0, bckoff_reg};
      ADDR_TIMING: rd_value = timing_reg;
      ADDR_MISC:   rd_value = misc_reg;
      ADDR_ID:     rd_value = {DEVICE_IDENTITY_CODE_P, REV_CODE_P};
      ADDR_FLAGS:  rd_value = {4'h0, flags_reg};
      ADDR_WDCNT:  rd_value = wd_cnt_reg;
      ADDR_SWMODE: rd_value = swmode_reg;
      default:     rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
      reg_rdata_out <= 8'h00;
    else if (reg_req_in.read)
      reg_rdata_out <= rd_value;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_all);

  sequence s_expire;
    wd_en && wd_cnt_reg == 8'h00 && !hw_mode;
  endsequence

  sequence s_deny;
    hw_mode && pwr_pb_reg[3:0] != 4'h0;
  endsequence

  a_on_has_button: assert property (
    ctrl_out.power_on != 4'h0 |->
      ($past(pwr_pb_reg[3:0]) & ctrl_out.power_on) == ctrl_out.power_on)
    else $error("power-on pulse without its button");

  a_on_not_powered: assert property (
    pwr_pb_reg[3:0] != 4'h0 |=>
      (ctrl_out.power_on & $past(port_stat_in.powered)) == 4'h0)
    else $error("power-on issued to a powered port");

  a_hw_refuses_on: assert property (
    s_deny |=> ctrl_out.power_on == 4'h0)
    else $error("power-on issued in hardware mode");

  a_deny_sets_flag: assert property (
    s_deny |=> (flags_reg & $past(pwr_pb_reg[3:0])) == $past(pwr_pb_reg[3:0]))
    else $error("denied request left flag clear");

  a_expiry_modes: assert property (
    s_expire |=> hw_mode && flags_reg == 4'hf
      && mode_reg == {{2{$past(swmode_reg[3])}}, {2{$past(swmode_reg[2])}},
                      {2{$past(swmode_reg[1])}}, {2{$past(swmode_reg[0])}}})
    else $error("expiry did not install fallback modes");

  a_wd_decrement: assert property (
    wd_en && wd_step && wd_cnt_reg != 8'h00
      && !hit(reg_req_in, ADDR_WDCNT, 1'b0)
      |=> wd_cnt_reg == $past(wd_cnt_reg) - 8'h01)
    else $error("watchdog step missed");

  a_wd_holds_zero: assert property (
    wd_cnt_reg == 8'h00 && !hit(reg_req_in, ADDR_WDCNT, 1'b0)
      |=> wd_cnt_reg == 8'h00)
    else $error("watchdog wrapped");

  // own disable: the default one would abort it on the reset it checks
  a_chip_reset: assert property (disable iff (rst_in)
    hit(reg_req_in, ADDR_GLOBPB, 1'b0) && reg_req_in.wdata[GPB_CHIP_BIT]
      |=> ##1 !rst_in -> (misc_reg == MISC_RST && timing_reg == TIMING_RST
                          && wd_cnt_reg == WDCNT_RST))
    else $error("chip reset left registers set");

  a_abort_then_on: assert property (
    ctrl_out.abort_discovery != 4'h0 |->
      (ctrl_out.abort_discovery & ~ctrl_out.power_on) == 4'h0)
    else $error("abort without power-on");

  a_restart_block: assert property (
    misc_reg[MISC_RESTART_BIT] && restart_cnt_reg[0] != '0
      |=> ctrl_out.power_block[0])
    else $error("restart timer did not block port");

  a_cadence_hold: assert property (
    port_stat_in.detect_fail[0] && bckoff_reg[0]
      |=> ##1 ctrl_out.cadence_hold[0])
    else $error("cadence hold not raised");

  a_takeover_irq: assert property (
    swmode_reg[SW_INT_BIT] && flags_reg != 4'h0 |=> takeover_irq_out)
    else $error("takeover interrupt missing");

endmodule

//--- rtl/pcwr_pkg.sv
// constants, field layouts and carrier types for the port config registers
// assumes a 20 MHz core clock and a register port fed by the serial front end
package pcwr_pkg;

  // clock and time base
  localparam int CLK_MHZ     = 20;
  localparam int TICK_US     = 10;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TW          = 22;

  // times in their own units, counts derived in 10 us ticks
  localparam int WD_STEP_US      = 164_000;
  localparam int WD_STEP_TICKS   = WD_STEP_US / TICK_US;
  localparam int CADENCE_US      = 2_200_000;
  localparam int CADENCE_TICKS   = CADENCE_US / TICK_US;
  localparam int TNOM_BASE_US    = 40_960;
  localparam int TNOM_STEP_US    = 2_720;
  localparam int DISC_NOM_US     = 350_000;
  localparam logic [TW-1:0] TNOM_BASE_TICKS = TW'(TNOM_BASE_US / TICK_US);
  localparam logic [TW-1:0] TNOM_STEP_TICKS = TW'(TNOM_STEP_US / TICK_US);
  localparam logic [TW-1:0] DISC_NOM_TICKS  = TW'(DISC_NOM_US / TICK_US);

  // register offsets
  localparam logic [7:0] ADDR_MODE   = 8'h12;
  localparam logic [7:0] ADDR_DISC   = 8'h13;
  localparam logic [7:0] ADDR_DETCLS = 8'h14;
  localparam logic [7:0] ADDR_BCKOFF = 8'h15;
  localparam logic [7:0] ADDR_TIMING = 8'h16;
  localparam logic [7:0] ADDR_MISC   = 8'h17;
  localparam logic [7:0] ADDR_PWRPB  = 8'h19;
  localparam logic [7:0] ADDR_GLOBPB = 8'h1a;
  localparam logic [7:0] ADDR_ID     = 8'h1b;
  localparam logic [7:0] ADDR_FLAGS  = 8'h1c;
  localparam logic [7:0] ADDR_WDCNT  = 8'h1e;
  localparam logic [7:0] ADDR_SWMODE = 8'h1f;

  // reset values and writable masks
  localparam logic [7:0] TIMING_RST  = 8'h00;
  localparam logic [7:0] MISC_RST    = 8'hc0;
  localparam logic [7:0] MISC_WMASK  = 8'hcf;
  localparam logic [7:0] SWMODE_RST  = 8'h00;
  localparam logic [7:0] SWMODE_WMSK = 8'hdf;
  localparam logic [7:0] WDCNT_RST   = 8'h00;
  localparam logic [3:0] FLAGS_RST   = 4'h0;

  // field positions
  localparam int MISC_RESTART_BIT = 6;
  localparam int MISC_CLFAIL_BIT  = 3;
  localparam int MISC_CLLIM_BIT   = 2;
  localparam int GPB_CLR_BIT      = 7;
  localparam int GPB_CHIP_BIT     = 4;
  localparam int SW_EN_BIT        = 7;
  localparam int SW_INT_BIT       = 6;
  localparam int TM_RSTR_LSB      = 6;
  localparam int TM_START_LSB     = 4;
  localparam int TM_FAULT_LSB     = 2;
  localparam int TM_DISC_LSB      = 0;

  // port mode codes
  localparam logic [1:0] MODE_SHUT = 2'b00;
  localparam logic [1:0] MODE_AUTO = 2'b11;

  // software or hardware control
  typedef enum logic [1:0] {
    CTL_SW = 2'b01,
    CTL_HW = 2'b10
  } pcwr_ctl_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } pcwr_req_type;

  typedef struct packed {
    logic [3:0] powered;
    logic [3:0] detecting;
    logic [3:0] class_fail;
    logic [3:0] oc_shutdown;
    logic [3:0] detect_fail;
  } pcwr_port_stat_type;

  typedef struct packed {
    logic [3:0] power_on;
    logic [3:0] power_off;
    logic [3:0] abort_discovery;
    logic [3:0] soft_reset;
    logic [3:0] power_block;
    logic [3:0] cadence_hold;
    logic       clear_all_events;
  } pcwr_ctrl_type;

  typedef struct packed {
    logic [3:0]    ac_disconnect_enable;
    logic [3:0]    dc_disconnect_enable;
    logic [3:0]    det_enable;
    logic [3:0]    class_enable;
    logic [3:0]    class_only;
    logic [3:0]    cadence_enable;
    logic          class_based_limit;
    logic [TW-1:0] fault_time;
    logic [TW-1:0] start_time;
    logic [TW-1:0] disc_time;
    logic [TW-1:0] restart_time;
  } pcwr_cfg_type;

endpackage

//--- bench/tb.sv
// self-checking bench for the port config and watchdog register bank
// assumes shortened watchdog step and cadence counts, straps tied low
`timescale 1ns/1ps
module tb
  import pcwr_pkg::*;
;
  logic               core_clk_in = 1'b0;
  logic               rst_in      = 1'b1;
  pcwr_req_type       req         = '0;
  pcwr_port_stat_type stat        = '0;
  logic [3:0]         fprog       = 4'h7;
  logic [3:0]         sprog       = 4'h7;
  logic [7:0]         rdata;
  pcwr_cfg_type       cfg;
  pcwr_ctrl_type      ctrl;
  logic               irq;
  int                 error_cnt   = 0;
  int                 check_count = 0;
  int                 cyc         = 0;
  // nominal time for programming value 7, in ticks
  int                 fn = TNOM_BASE_US / TICK_US
                           + 7 * (TNOM_STEP_US / TICK_US);
  int                 dn = DISC_NOM_US / TICK_US;

  pcwr_regs #(.WD_STEP_TICKS_P(4), .CADENCE_TICKS_P(5)) uut (
    .core_clk_in      (core_clk_in),
    .rst_in           (rst_in),
    .auto_pin_in      (1'b0),
    .midspan_pin_in   (1'b0),
    .reg_req_in       (req),
    .port_stat_in     (stat),
    .fault_prog_in    (fprog),
    .start_prog_in    (sprog),
    .reg_rdata_out    (rdata),
    .cfg_out          (cfg),
    .ctrl_out         (ctrl),
    .takeover_irq_out (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a cycle ceiling well above the watchdog wait
  initial
  begin
    forever #25 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one strobe cycle; returns just after the edge that took it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in) #1;
    req = '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge core_clk_in) #1 req.write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in) #1;
    req = '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge core_clk_in) #1 req.read = 1'b0;
    chk(rdata, exp);
  endtask
  // button write, then one edge: the pulse stands for that cycle only
  task automatic pb(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    @(posedge core_clk_in);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_id();
    rd(ADDR_MISC, 8'hc0);
    rd(ADDR_TIMING, 8'h00);
    rd(ADDR_FLAGS, 8'h00);
    rd(ADDR_WDCNT, 8'h00);
    rd(ADDR_PWRPB, 8'h00);
    wr(ADDR_ID, 8'hff);
    rd(ADDR_ID, {5'h0a, 3'h1});
  endtask

  task automatic t_enables();
    wr(ADDR_DISC, 8'ha5);
    @(posedge core_clk_in) #1;
    chk({cfg.ac_disconnect_enable, cfg.dc_disconnect_enable}, 8'ha5);
    wr(ADDR_DETCLS, 8'h3c);
    @(posedge core_clk_in) #1;
    chk({cfg.class_enable, cfg.det_enable, cfg.class_only}, 12'h3c3);
    wr(ADDR_BCKOFF, 8'hff);
    rd(ADDR_BCKOFF, 8'h0f);
    chk(cfg.cadence_enable, 4'hf);
  endtask

  task automatic tcase(input logic [7:0] c, input int r, s, f, d);
    wr(ADDR_TIMING, c);
    @(posedge core_clk_in) #1;
    chk(cfg.restart_time, r);
    chk(cfg.start_time, s);
    chk(cfg.fault_time, f);
    chk(cfg.disc_time, d);
  endtask

  // manual mode on all ports, port 1 in discovery, port 2 powered
  task automatic t_buttons();
    wr(ADDR_MODE, 8'h55);
    stat.detecting = 4'h1;
    stat.powered   = 4'h2;
    pb(ADDR_PWRPB, 8'h01);
    chk({ctrl.power_on, ctrl.abort_discovery}, 8'h11);
    @(posedge core_clk_in) #1;
    chk(ctrl.power_on, 4'h0);
    pb(ADDR_PWRPB, 8'h12);
    chk({ctrl.power_on, ctrl.power_off}, 8'h00);
    pb(ADDR_PWRPB, 8'h20);
    chk(ctrl.power_off, 4'h2);
    pb(ADDR_PWRPB, 8'h00);
    chk({ctrl.power_on, ctrl.power_off}, 8'h00);
    pb(ADDR_GLOBPB, 8'h04);
    chk({ctrl.soft_reset, ctrl.power_off}, 8'h44);
    rd(ADDR_MODE, 8'h55);
    pb(ADDR_GLOBPB, 8'h80);
    chk(ctrl.clear_all_events, 1'b1);
  endtask

  task automatic t_watchdog();
    int n;
    n = 0;
    wr(ADDR_WDCNT, 8'h01);
    wr(ADDR_SWMODE, 8'hc1);
    chk(irq, 1'b0);
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk_in) #1;
      n++;
    end
    chk(n > 700 && n < 1000, 1'b1);
    rd(ADDR_MODE, 8'h03);
    rd(ADDR_WDCNT, 8'h00);
    rd(ADDR_FLAGS, 8'h0f);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_MODE, 8'h55);
    rd(ADDR_MODE, 8'h03);
    stat.powered = 4'h0;
    pb(ADDR_PWRPB, 8'h01);
    chk(ctrl.power_on, 4'h0);
    rd(ADDR_FLAGS, 8'h01);
    wr(ADDR_SWMODE, 8'h00);
  endtask

  // host keeps rewriting the counter, so no expiry may happen
  task automatic t_keepalive();
    wr(ADDR_WDCNT, 8'h02);
    wr(ADDR_SWMODE, 8'h80);
    for (int i = 0; i < 6; i++)
    begin
      repeat (400) @(posedge core_clk_in);
      wr(ADDR_WDCNT, 8'h02);
    end
    rd(ADDR_MODE, 8'h03);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_SWMODE, 8'h00);
  endtask

  // port 1 manual, 2 auto, 3 manual, 4 shutdown; timers and blocks
  task automatic t_protect();
    wr(ADDR_MISC, 8'hcc);
    @(posedge core_clk_in) #1;
    chk(cfg.class_based_limit, 1'b1);
    wr(ADDR_MODE, 8'h1d);
    pb(ADDR_PWRPB, 8'h0b);
    chk(ctrl.power_on, 4'h1);
    stat.oc_shutdown = 4'h1;
    @(posedge core_clk_in) #1;
    stat.oc_shutdown = 4'h0;
    pb(ADDR_PWRPB, 8'h01);
    chk({ctrl.power_on, ctrl.power_block}, 8'h01);
    stat.class_fail = 4'h6;
    @(posedge core_clk_in) #1;
    chk(ctrl.power_block, 4'h3);
    stat.class_fail = 4'h0;
    stat.detect_fail = 4'h9;
    @(posedge core_clk_in) #1;
    stat.detect_fail = 4'h0;
    @(posedge core_clk_in) #1;
    chk(ctrl.cadence_hold, 4'h9);
    repeat (750) @(posedge core_clk_in);
    #1;
    chk(ctrl.cadence_hold, 4'h9);
    repeat (300) @(posedge core_clk_in);
    #1;
    chk(ctrl.cadence_hold, 4'h0);
  endtask

  task automatic t_chip_reset();
    wr(ADDR_MISC, 8'h0c);
    rd(ADDR_MISC, 8'h0c);
    wr(ADDR_GLOBPB, 8'h10);
    repeat (3) @(posedge core_clk_in);
    rd(ADDR_MISC, 8'hc0);
    rd(ADDR_DISC, 8'h00);
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge core_clk_in);
    #1 rst_in = 1'b0;
    t_reset_id();
    t_enables();
    tcase(8'h31, 16 * fn, 4 * fn, fn, dn / 4);
    tcase(8'he6, 0, 2 * fn, fn / 2, dn / 2);
    tcase(8'h4b, 64 * fn, fn, 2 * fn, 2 * dn);
    tcase(8'h80, 64 * fn, fn, fn, dn);
    t_buttons();
    t_watchdog();
    t_keepalive();
    t_protect();
    t_chip_reset();
    conclude();
  end
endmodule
